/* conversion_source_mode_ctrl_test.sv */
// conversion_source_mode_ctrl_test: self-checking bench for cssm_ctrl
// assumes: cssm_host_model drives apb and sync; 250 MHz mclk
`timescale 1ns/1ps
module conversion_source_mode_ctrl_test;
   import cssm_pkg::*;
   logic mclk;
   logic rst_b;
   cssm_apb_req_t req;
   logic [31:0] prdata;
   logic pready, pslverr, sync_trig, conv_input_sel, diag_mux_en;
   logic diag_zero_short, diag_pos_fs, diag_neg_fs, diag_temp_en;
   logic modulator_on, converting, in_standby, result_ready_pulse, irq;
   logic [3:0] diag_source_sel;
   logic [31:0] d;
   logic e;
   int n, g1, g2;
   int n_fail = 0;
   int checks_done = 0;
   // ==========================================================
   // clock, host and design
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   cssm_host_model host_u (.mclk(mclk), .req(req), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sync_trig(sync_trig));
   cssm_ctrl dut_u (.mclk(mclk), .rst_b(rst_b), .psel(req.psel),
      .penable(req.penable), .pwrite(req.pwrite), .paddr(req.paddr),
      .pwdata(req.pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sync_trig(sync_trig),
      .diag_source_sel(diag_source_sel), .conv_input_sel(conv_input_sel),
      .diag_mux_en(diag_mux_en), .diag_zero_short(diag_zero_short),
      .diag_pos_fs(diag_pos_fs), .diag_neg_fs(diag_neg_fs),
      .diag_temp_en(diag_temp_en), .modulator_on(modulator_on),
      .converting(converting), .in_standby(in_standby),
      .result_ready_pulse(result_ready_pulse), .irq(irq));
   // ==========================================================
   // helpers
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] v);
      host_u.xfer(1'b1, a, v, d, e);
   endtask
   task automatic rd(logic [7:0] a);
      host_u.xfer(1'b0, a, 32'h0, d, e);
   endtask
   task automatic ctl(logic [3:0] dg, logic ins, logic [2:0] m);
      wr(CSSM_OFS_CTRL, {24'h0, dg, ins, m});
   endtask
   // cycles to next result pulse, -1 when none within maxc
   task automatic wait_pulse(int maxc, output int k);
      k = 0;
      while (k < maxc && result_ready_pulse !== 1'b1) begin
         @(posedge mclk);
         k++;
      end
      if (result_ready_pulse !== 1'b1) k = -1;
      @(posedge mclk);
   endtask
   task automatic count_pulses(int cyc, output int k);
      k = 0;
      repeat (cyc) begin
         @(posedge mclk);
         if (result_ready_pulse === 1'b1) k++;
      end
   endtask
   function automatic logic in_win(int k, int lo, int hi);
      return k >= lo && k <= hi;
   endfunction
   // ==========================================================
   // scenarios
   task automatic t_reset;
      rd(CSSM_OFS_CTRL);
      check("ctrl_rst", d, 32'h0);
      check("diag_rst", diag_source_sel, 4'h0);
      check("insel_rst", conv_input_sel, 1'b0);
      rd(CSSM_OFS_PER);
      check("per_rst", d, {16'h0, CSSM_PER_RST});
      rd(CSSM_OFS_INFO);
      check("info", d, CSSM_INFO_VAL);
      rd(8'h40);
      check("unmapped_rd", d, 32'h0);
      check("unmapped_err", e, 1'b1);
      wr(8'h40, 32'hFF);
      check("unmapped_wr", e, 1'b1);
      $display("test reset done");
   endtask
   task automatic t_diag;
      logic [3:0] c;
      logic [3:0] codes[4];
      codes = '{CSSM_DIAG_TEMP, CSSM_DIAG_ZERO, CSSM_DIAG_PFS, CSSM_DIAG_NFS};
      for (int i = 0; i < 4; i++) begin
         c = codes[i];
         ctl(c, 1'b1, 3'h4);
         repeat (2) @(posedge mclk);
         check("diag_sel", diag_source_sel, c);
         check("route", {diag_temp_en, diag_zero_short, diag_pos_fs,
               diag_neg_fs}, {c == 4'h0, c == 4'h8, c == 4'h9,
               c == 4'hA});
         check("mux_en", {conv_input_sel, diag_mux_en}, 2'h3);
         rd(CSSM_OFS_CTRL);
         check("ctrl_rb", d, {24'h0, c, 4'hC});
      end
      // reserved code must enable no source
      ctl(4'h5, 1'b1, 3'h4);
      repeat (2) @(posedge mclk);
      check("reserved", {diag_temp_en, diag_zero_short, diag_pos_fs,
            diag_neg_fs}, 4'h0);
      ctl(4'h0, 1'b0, 3'h4);
      repeat (2) @(posedge mclk);
      check("pair_in", {conv_input_sel, diag_mux_en}, 2'h0);
      $display("test diag done");
   endtask
   task automatic t_cont;
      ctl(4'h0, 1'b0, 3'h0);
      wait_pulse(400, n);
      wait_pulse(400, n);
      check("cont_gap", n, CSSM_FILT_CYC - 1);
      check("mod_on", modulator_on, 1'b1);
      check("conv_on", converting, 1'b1);
      $display("test continuous done");
   endtask
   task automatic t_stby;
      for (int m = 4; m < 8; m++) begin
         ctl(4'h0, 1'b0, 3'(m));
         repeat (2) @(posedge mclk);
         count_pulses(150, n);
         check("stby_pulses", n, 0);
         check("stby_lvl", in_standby, 1'b1);
         check("stby_conv", converting, 1'b0);
      end
      $display("test standby done");
   endtask
   task automatic t_trig;
      ctl(4'h0, 1'b0, 3'h1);
      count_pulses(150, n);
      check("no_edge", n, 0);
      host_u.pulse_sync(2);
      wait_pulse(400, n);
      check("trig_lat", in_win(n, CSSM_SETTLE_CYC - 2,
            CSSM_SETTLE_CYC + 6), 1'b1);
      count_pulses(150, n);
      check("one_per_edge", n, 0);
      $display("test trigger done");
   endtask
   task automatic t_single;
      wr(CSSM_OFS_MASK, 32'h0);
      ctl(4'h0, 1'b0, 3'h4);
      rd(CSSM_OFS_STAT);
      for (int r = 0; r < 2; r++) begin
         ctl(4'h0, 1'b0, 3'h2);
         wait_pulse(600, n);
         check("single_lat", in_win(n, CSSM_WAKE_CYC + CSSM_SETTLE_CYC - 1,
               CSSM_WAKE_CYC + CSSM_SETTLE_CYC + 6), 1'b1);
         repeat (3) @(posedge mclk);
         check("back_stby", in_standby, 1'b1);
         count_pulses(200, n);
         check("one_result", n, 0);
      end
      check("irq_masked", irq, 1'b0);
      wr(CSSM_OFS_MASK, 32'h1);
      repeat (2) @(posedge mclk);
      check("irq_on", irq, 1'b1);
      rd(CSSM_OFS_STAT);
      check("stat_res", d[CSSM_EV_RES], 1'b1);
      repeat (2) @(posedge mclk);
      check("irq_clr", irq, 1'b0);
      $display("test single done");
   endtask
   task automatic t_period;
      wr(CSSM_OFS_PER, 32'h4);
      ctl(4'h0, 1'b0, 3'h3);
      wait_pulse(1000, n);
      wait_pulse(1000, g1);
      // gap is standby count of 4, wake, settle, plus edge overhead
      check("auto_wake", in_win(g1, CSSM_WAKE_CYC + CSSM_SETTLE_CYC + 3,
            CSSM_WAKE_CYC + CSSM_SETTLE_CYC + 10), 1'b1);
      wr(CSSM_OFS_PER, 32'h28);
      wait_pulse(1000, n);
      wait_pulse(1000, g2);
      check("ratio_reg", g2 - g1, 32'h24);
      $display("test periodic done");
   endtask
   // ==========================================================
   // verdict
   task automatic tally_and_finish;
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      #(4 * 60000);
      n_fail++;
      $display("watchdog expired");
      tally_and_finish;
   end
   initial begin
      rst_b = 1'b0;
      repeat (3) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (5) @(posedge mclk);
      t_reset;
      t_diag;
      t_cont;
      t_stby;
      t_trig;
      t_single;
      t_period;
      tally_and_finish;
   end
endmodule

/* cssm_ctrl.sv */
// cssm_ctrl: conversion source select and conversion mode sequencer
// assumes: apb master on mclk; sync trigger is an asynchronous pin
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module cssm_ctrl (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // trigger pin
   input wire logic sync_trig,
   // conversion outputs
   output logic [3:0] diag_source_sel,
   output logic conv_input_sel,
   output logic diag_mux_en,
   output logic diag_zero_short,
   output logic diag_pos_fs,
   output logic diag_neg_fs,
   output logic diag_temp_en,
   output logic modulator_on,
   output logic converting,
   output logic in_standby,
   output logic result_ready_pulse,
   output logic irq
);
   import cssm_pkg::*;

   // ==========================================================
   // reset release
   logic rst_s1_q, rst_n;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n <= rst_s1_q;
      end
   end

   // ==========================================================
   // apb decode; answers in the access cycle, zero wait states
   cssm_apb_req_t req;
   assign req = '{psel, penable, pwrite, paddr, pwdata};
   logic acc, wr, rd, hit_ctrl, hit_stat, hit_mask, hit_per, hit_info, hit;
   assign acc = req.psel & req.penable;
   assign wr = acc & req.pwrite;
   assign rd = acc & ~req.pwrite;
   assign hit_ctrl = req.paddr == CSSM_OFS_CTRL;
   assign hit_stat = req.paddr == CSSM_OFS_STAT;
   assign hit_mask = req.paddr == CSSM_OFS_MASK;
   assign hit_per = req.paddr == CSSM_OFS_PER;
   assign hit_info = req.paddr == CSSM_OFS_INFO;
   assign hit = hit_ctrl | hit_stat | hit_mask | hit_per | hit_info;
   assign pready = 1'b1;
   assign pslverr = acc & ~hit;

   // ==========================================================
   // control register
   cssm_ctrl_t ctrl_q;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= CSSM_CTRL_RST;
      end else if (wr && hit_ctrl) begin
         ctrl_q <= cssm_ctrl_t'(req.pwdata[7:0]);
      end
   end

   // periodic ratio lives in the store, apart from control
   logic [15:0] per_ratio;
   logic [15:0] per_ratio_q;
   cssm_store u_store (
      .clk(mclk),
      .rst_n(rst_n),
      .we(wr & hit_per),
      .waddr(2'h0),
      .wdata(req.pwdata[15:0]),
      .raddr(2'h0),
      .rdata(per_ratio)
   );
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         per_ratio_q <= CSSM_PER_RST;
      end else begin
         per_ratio_q <= per_ratio;
      end
   end

   // ==========================================================
   // sync pin: three flops, edge when second and third agree
   logic [2:0] sync_sh_q;
   logic sync_lvl_q, sync_rise;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sync_sh_q <= 3'h0;
      end else begin
         sync_sh_q <= {sync_sh_q[1:0], sync_trig};
      end
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sync_lvl_q <= 1'b0;
      end else if (sync_sh_q[1] == sync_sh_q[2]) begin
         sync_lvl_q <= sync_sh_q[2];
      end
   end
   assign sync_rise = (sync_sh_q[1] == sync_sh_q[2]) & sync_sh_q[2]
      & ~sync_lvl_q;

   // ==========================================================
   // sequencer
   typedef enum logic [2:0] {
      CSSM_S_STBY = 3'h0,
      CSSM_S_WAKE = 3'h1,
      CSSM_S_CONV = 3'h2,
      CSSM_S_IDLE = 3'h3,
      CSSM_S_RUN = 3'h4,
      CSSM_S_DONE = 3'h5
   } cssm_state_t;
   cssm_state_t st_q, st_d;
   logic [15:0] cnt_q, cnt_d;
   logic [2:0] mode;
   logic mode_wr, res_d, stby_ev, wake_ev;
   assign mode = ctrl_q.conversion_scheme;
   assign mode_wr = wr & hit_ctrl;

   always_comb begin
      st_d = st_q;
      cnt_d = (cnt_q == 16'h0000) ? 16'h0000 : 16'(cnt_q - 16'h0001);
      res_d = 1'b0;
      stby_ev = 1'b0;
      wake_ev = 1'b0;
      unique case (st_q)
         CSSM_S_STBY: begin
            if (mode == CSSM_M_CONT || mode == CSSM_M_TRIG) begin
               st_d = CSSM_S_WAKE;
               cnt_d = CSSM_WAKE_CYC;
            end else if (mode_wr && req.pwdata[2:0] == CSSM_M_SINGLE) begin
               st_d = CSSM_S_WAKE;
               cnt_d = CSSM_WAKE_CYC;
            end else if (mode == CSSM_M_PERIOD && cnt_q == 16'h0000) begin
               st_d = CSSM_S_WAKE;
               cnt_d = CSSM_WAKE_CYC;
               wake_ev = 1'b1;
            end
         end
         CSSM_S_WAKE: begin
            if (mode[2]) begin
               st_d = CSSM_S_STBY;
            end else if (cnt_q == 16'h0001 || cnt_q == 16'h0000) begin
               if (mode == CSSM_M_CONT) begin
                  st_d = CSSM_S_RUN;
                  cnt_d = CSSM_FILT_CYC;
               end else if (mode == CSSM_M_TRIG) begin
                  st_d = CSSM_S_IDLE;
               end else begin
                  st_d = CSSM_S_CONV;
                  cnt_d = CSSM_SETTLE_CYC;
               end
            end
         end
         CSSM_S_RUN: begin
            if (mode != CSSM_M_CONT) begin
               st_d = mode[2] ? CSSM_S_STBY : CSSM_S_IDLE;
            end else if (cnt_q == 16'h0001) begin
               res_d = 1'b1;
               cnt_d = CSSM_FILT_CYC;
            end
         end
         CSSM_S_IDLE: begin
            if (mode[2]) begin
               st_d = CSSM_S_STBY;
            end else if (mode == CSSM_M_CONT) begin
               st_d = CSSM_S_RUN;
               cnt_d = CSSM_FILT_CYC;
            end else if (mode != CSSM_M_TRIG) begin
               st_d = CSSM_S_STBY;
            end else if (sync_rise) begin
               st_d = CSSM_S_CONV;
               cnt_d = CSSM_SETTLE_CYC;
            end
         end
         CSSM_S_CONV: begin
            if (mode[2]) begin
               st_d = CSSM_S_STBY;
            end else if (mode == CSSM_M_TRIG && sync_rise) begin
               cnt_d = CSSM_SETTLE_CYC;
            end else if (cnt_q == 16'h0001) begin
               st_d = CSSM_S_DONE;
               res_d = 1'b1;
            end
         end
         CSSM_S_DONE: begin
            if (mode == CSSM_M_TRIG || mode == CSSM_M_CONT) begin
               st_d = mode == CSSM_M_TRIG ? CSSM_S_IDLE : CSSM_S_RUN;
               cnt_d = CSSM_FILT_CYC;
            end else begin
               st_d = CSSM_S_STBY;
               stby_ev = 1'b1;
               cnt_d = mode == CSSM_M_PERIOD ? per_ratio_q : 16'h0000;
            end
         end
         default: begin
            st_d = CSSM_S_STBY;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= CSSM_S_STBY;
         cnt_q <= 16'h0000;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
      end
   end

   // ==========================================================
   // conversion outputs, all registered
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         result_ready_pulse <= 1'b0;
         modulator_on <= 1'b0;
         converting <= 1'b0;
         in_standby <= 1'b1;
      end else begin
         result_ready_pulse <= res_d;
         modulator_on <= st_d inside {CSSM_S_RUN, CSSM_S_IDLE,
            CSSM_S_CONV, CSSM_S_DONE};
         converting <= st_d inside {CSSM_S_RUN, CSSM_S_CONV};
         in_standby <= st_d == CSSM_S_STBY;
      end
   end

   // reserved diag codes drive no source; result undefined
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         diag_source_sel <= 4'h0;
         conv_input_sel <= 1'b0;
         diag_mux_en <= 1'b0;
         diag_temp_en <= 1'b0;
         diag_zero_short <= 1'b0;
         diag_pos_fs <= 1'b0;
         diag_neg_fs <= 1'b0;
      end else begin
         diag_source_sel <= ctrl_q.diag_source_sel;
         conv_input_sel <= ctrl_q.conv_input_sel;
         diag_mux_en <= ctrl_q.conv_input_sel;
         diag_temp_en <= ctrl_q.diag_source_sel == CSSM_DIAG_TEMP;
         diag_zero_short <= ctrl_q.diag_source_sel == CSSM_DIAG_ZERO;
         diag_pos_fs <= ctrl_q.diag_source_sel == CSSM_DIAG_PFS;
         diag_neg_fs <= ctrl_q.diag_source_sel == CSSM_DIAG_NFS;
      end
   end

   // ==========================================================
   // interrupts: sticky, read clears, set wins
   logic [2:0] stat_q, mask_q, ev;
   assign ev = {wake_ev, stby_ev, res_d};
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         stat_q <= CSSM_IRQ_RST;
      end else begin
         stat_q <= ((rd && hit_stat) ? 3'h0 : stat_q) | ev;
      end
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mask_q <= CSSM_IRQ_RST;
      end else if (wr && hit_mask) begin
         mask_q <= req.pwdata[2:0];
      end
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(stat_q & mask_q);
      end
   end

   // ==========================================================
   // read mux; registered data would cost a wait state, so combinational
   always_comb begin
      prdata = 32'h0000_0000;
      if (rd) begin
         if (hit_ctrl) prdata = {24'h000000, ctrl_q};
         if (hit_stat) prdata = {29'h0, stat_q};
         if (hit_mask) prdata = {29'h0, mask_q};
         if (hit_per) prdata = {16'h0000, per_ratio_q};
         if (hit_info) prdata = CSSM_INFO_VAL;
      end
   end

   // ==========================================================
   // checks
   chk_reset_ctrl: assert property (@(posedge mclk)
      $rose(rst_n) |-> ctrl_q == 8'h00)
      else $error("control not zero after reset");
   chk_hi_mode_stby: assert property (@(posedge mclk) disable iff (!rst_n)
      mode[2] && $past(mode[2]) |=> !converting)
      else $error("conversion in standby mode code");
   chk_trig_start: assert property (@(posedge mclk) disable iff (!rst_n)
      st_q == CSSM_S_IDLE && mode == CSSM_M_TRIG && sync_rise
      |=> st_q == CSSM_S_CONV)
      else $error("sync edge did not start conversion");
   chk_trig_ready: assert property (@(posedge mclk) disable iff (!rst_n)
      st_q == CSSM_S_CONV && st_d == CSSM_S_DONE |=> result_ready_pulse)
      else $error("no ready after conversion");
   chk_single_stby: assert property (@(posedge mclk) disable iff (!rst_n)
      st_q == CSSM_S_DONE && mode == CSSM_M_SINGLE
      |=> ##1 in_standby)
      else $error("single mode did not enter standby");
   chk_wake_time: assert property (@(posedge mclk) disable iff (!rst_n)
      st_q == CSSM_S_STBY && st_d == CSSM_S_WAKE && !mode[2]
      |=> !converting [*2])
      else $error("converted without start-up");
   chk_cont_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
      st_q == CSSM_S_RUN && mode == CSSM_M_CONT && cnt_q == 16'h0001
      |=> result_ready_pulse)
      else $error("missing continuous ready pulse");
   chk_insel_out: assert property (@(posedge mclk) disable iff (!rst_n)
      ##1 conv_input_sel == $past(ctrl_q.conv_input_sel))
      else $error("input select not following register");
   chk_diag_zero: assert property (@(posedge mclk) disable iff (!rst_n)
      ctrl_q.diag_source_sel == 4'h8 |=> diag_zero_short)
      else $error("zero check source not routed");
   chk_period_wake: assert property (@(posedge mclk) disable iff (!rst_n)
      st_q == CSSM_S_STBY && mode == CSSM_M_PERIOD && cnt_q == 16'h0000
      |=> st_q == CSSM_S_WAKE)
      else $error("periodic mode did not wake");
endmodule

/* cssm_host_model.sv */
// cssm_host_model: host side facing cssm_ctrl, apb master and sync pin
// assumes: one clock mclk; every change lands just after its rising edge
`timescale 1ns/1ps
module cssm_host_model (
   // clock
   input wire logic mclk,
   // apb master
   output cssm_pkg::cssm_apb_req_t req,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // trigger pin
   output logic sync_trig
);
   import cssm_pkg::*;
   // ==========================================================
   // idle values
   initial begin
      req = '0;
      sync_trig = 1'b0;
   end
   // ==========================================================
   // apb transfer, waits on pready with no fixed count
   // low power setup lives outside this block
   task automatic xfer(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
      @(posedge mclk);
      req <= '{psel:1'b1, penable:1'b0, pwrite:wr, paddr:a, pwdata:d};
      @(posedge mclk);
      req.penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      // released lines show the inverse, never a stale copy
      req <= '{psel:1'b0, penable:1'b0, pwrite:~wr, paddr:~a, pwdata:~d};
   endtask
   // ==========================================================
   // sync pin: low-to-high edge, held for a few cycles
   task automatic pulse_sync(input int hold);
      @(posedge mclk);
      sync_trig <= 1'b1;
      repeat (hold) @(posedge mclk);
      sync_trig <= 1'b0;
   endtask
endmodule

/* cssm_pkg.sv */
// cssm_pkg: constants and carrier types for the conversion source/mode block
// assumes: imported by cssm_ctrl and cssm_store
package cssm_pkg;
   // ==========================================================
   // register map
   localparam logic [7:0] CSSM_OFS_CTRL = 8'h18;
   localparam logic [7:0] CSSM_OFS_STAT = 8'h1C;
   localparam logic [7:0] CSSM_OFS_MASK = 8'h20;
   localparam logic [7:0] CSSM_OFS_PER = 8'h24;
   localparam logic [7:0] CSSM_OFS_INFO = 8'h28;
   localparam logic [7:0] CSSM_CTRL_RST = 8'h00;
   localparam logic [2:0] CSSM_IRQ_RST = 3'h0;
   localparam logic [15:0] CSSM_PER_RST = 16'h0004;
   // ==========================================================
   // field positions
   localparam int CSSM_DIAG_HI = 7;
   localparam int CSSM_DIAG_LO = 4;
   localparam int CSSM_INSEL_BIT = 3;
   localparam int CSSM_MODE_HI = 2;
   // status bits
   localparam int CSSM_EV_RES = 0;
   localparam int CSSM_EV_STBY = 1;
   localparam int CSSM_EV_WAKE = 2;
   // ==========================================================
   // diagnostic source codes
   localparam logic [3:0] CSSM_DIAG_TEMP = 4'h0;
   localparam logic [3:0] CSSM_DIAG_ZERO = 4'h8;
   localparam logic [3:0] CSSM_DIAG_PFS = 4'h9;
   localparam logic [3:0] CSSM_DIAG_NFS = 4'hA;
   // ==========================================================
   // timing
   localparam int CSSM_CLK_MHZ = 250;
   localparam int CSSM_SETTLE_NS = 400;
   localparam int CSSM_WAKE_NS = 200;
   localparam int CSSM_FILT_NS = 100;
   localparam logic [15:0] CSSM_SETTLE_CYC =
      16'((CSSM_SETTLE_NS * CSSM_CLK_MHZ + 999) / 1000);
   localparam logic [15:0] CSSM_WAKE_CYC =
      16'((CSSM_WAKE_NS * CSSM_CLK_MHZ + 999) / 1000);
   localparam logic [15:0] CSSM_FILT_CYC =
      16'((CSSM_FILT_NS * CSSM_CLK_MHZ + 999) / 1000);
   localparam logic [31:0] CSSM_INFO_VAL = 32'h0000_5A5A; // arbitrary value
   // ==========================================================
   // types
   typedef enum logic [2:0] {
      CSSM_M_CONT = 3'h0,
      CSSM_M_TRIG = 3'h1,
      CSSM_M_SINGLE = 3'h2,
      CSSM_M_PERIOD = 3'h3
   } cssm_mode_t;
   typedef struct packed {
      logic [3:0] diag_source_sel;
      logic conv_input_sel;
      logic [2:0] conversion_scheme;
   } cssm_ctrl_t;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } cssm_apb_req_t;
endpackage

/* cssm_store.sv */
// cssm_store: small register store with registered read data
// assumes: single clock, synchronous write, one-cycle read latency
`timescale 1ns/1ps
module cssm_store (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // write side
   input wire logic we,
   input wire logic [1:0] waddr,
   input wire logic [15:0] wdata,
   // read side
   input wire logic [1:0] raddr,
   output logic [15:0] rdata
);
   import cssm_pkg::*;
   logic [15:0] mem_q [4];
   // ==========================================================
   // storage; entry 0 holds the periodic standby ratio
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_q[0] <= CSSM_PER_RST;
         mem_q[1] <= 16'h0000;
         mem_q[2] <= 16'h0000;
         mem_q[3] <= 16'h0000;
      end else if (we) begin
         mem_q[waddr] <= wdata;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 16'h0000;
      end else begin
         rdata <= mem_q[raddr];
      end
   end
endmodule
